// ==== hdl/pwmi_consts.svh ====
// Constants for the periodic wake-up and monitor interrupt block.
// Assumes a single 25 MHz system clock and plain-port control bits.
// Functional notes
// - Low-voltage status follows comparator in full performance.
// - Low-voltage status change sets flag; enable gates request.
// - High-temp status follows comparator in full performance.
// - High-temp status change sets flag; enable gates request.
// - Timer counts only when enabled; enable starts period.
// - Clock is RC or bus; stopped bus freezes.
// - Clock select written only while timer disabled.
// - 16-bit period written only while timer disabled.
// - Elapsed interval sets flag and restarts automatically.
// - Periodic request while flag and enable both set.
// - First interval may be shortened by start-up delay.
// - Wave output driven when enable and external enable.
`ifndef PWMI_CONSTS_SVH
`define PWMI_CONSTS_SVH
`define PWMI_PERIOD_W 16
`define PWMI_PERIOD_RST 16'h0000
`define PWMI_CLK_SEL_RC 1'b0
`define PWMI_CLK_SEL_BUS 1'b1
`define PWMI_TRIM_W 6
`endif

// ==== hdl/pwmi_pkg.sv ====
// Types for the periodic wake-up and monitor interrupt block.
// Assumes the constants header is available on the include path.
`include "pwmi_consts.svh"
package pwmi_pkg;
  typedef struct packed {
    logic low_voltage;
    logic high_temp;
    logic periodic;
  } pwmi_irq_t;
  typedef struct packed {
    logic low_voltage;
    logic high_temp;
    logic periodic;
  } pwmi_flag_t;
endpackage : pwmi_pkg

// ==== hdl/pwmi_top.sv ====
// Monitor change flags and autonomous periodic timer with interrupts.
// Assumes comparator and tick inputs are asynchronous pins; controls are on clk_sys.
`timescale 1ns/10ps
`include "pwmi_consts.svh"
module pwmi_top
  import pwmi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Mode, analog comparators and clock ticks (asynchronous)
  input wire logic full_performance_mode,
  input wire logic low_voltage_cmp,
  input wire logic high_temp_cmp,
  input wire logic rc_clock_tick,
  input wire logic bus_clock_tick,
  // Control
  input wire logic low_voltage_irq_enable,
  input wire logic high_temp_irq_enable,
  input wire logic periodic_irq_enable,
  input wire logic periodic_timer_enable,
  input wire logic periodic_external_enable,
  input wire logic cfg_write,
  input wire logic periodic_clock_select_wdata,
  input wire logic [`PWMI_PERIOD_W-1:0] periodic_interval_wdata,
  input wire pwmi_flag_t flag_clear,
  // Status
  output logic low_voltage_status,
  output logic high_temp_status,
  output logic periodic_clock_select,
  output logic [`PWMI_PERIOD_W-1:0] periodic_interval,
  output pwmi_flag_t flags,
  output pwmi_irq_t irq,
  output logic periodic_wave_out
);

  // Two-stage synchronisers for asynchronous inputs
  logic [4:0] sync1_reg, sync2_reg, sync_next;
  logic tick_prev_reg, tick_prev_next;
  logic fpm_s, lv_s, ht_s, rc_s, bus_s, tick_s, tick_edge;

  always_comb begin
    sync_next = {full_performance_mode, low_voltage_cmp, high_temp_cmp,
                 rc_clock_tick, bus_clock_tick};
  end
  assign {fpm_s, lv_s, ht_s, rc_s, bus_s} = sync2_reg;
  // Selected tick source; a stopped bus clock gives no edges, so count freezes
  assign tick_s = (periodic_clock_select == `PWMI_CLK_SEL_BUS) ? bus_s : rc_s;
  assign tick_edge = tick_s & ~tick_prev_reg;
  always_comb begin
    tick_prev_next = tick_s;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      tick_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync_next;
      sync2_reg <= sync1_reg;
      tick_prev_reg <= tick_prev_next;
    end
  end

  // Monitor status and change flags
  logic lvs_reg, lvs_next, hts_reg, hts_next;
  pwmi_flag_t flag_reg, flag_next;
  logic [`PWMI_PERIOD_W-1:0] count_reg, count_next, intv_reg, intv_next;
  logic csel_reg, csel_next, en_prev_reg, en_prev_next, wave_reg, wave_next;
  logic elapsed;

  always_comb begin
    lvs_next = lvs_reg;
    hts_next = hts_reg;
    if (fpm_s) begin
      lvs_next = lv_s;
      hts_next = ht_s;
    end
  end

  // Set wins over a simultaneous clear
  always_comb begin
    flag_next = flag_reg;
    if (flag_clear.low_voltage) flag_next.low_voltage = 1'b0;
    if (flag_clear.high_temp) flag_next.high_temp = 1'b0;
    if (flag_clear.periodic) flag_next.periodic = 1'b0;
    if (lvs_next != lvs_reg) flag_next.low_voltage = 1'b1;
    if (hts_next != hts_reg) flag_next.high_temp = 1'b1;
    if (elapsed) flag_next.periodic = 1'b1;
  end

  // Periodic timer: counts ticks from zero up to interval, then restarts
  assign elapsed = periodic_timer_enable && tick_edge && (count_reg >= intv_reg);
  always_comb begin
    csel_next = csel_reg;
    intv_next = intv_reg;
    count_next = count_reg;
    wave_next = wave_reg;
    en_prev_next = periodic_timer_enable;
    if (cfg_write && !periodic_timer_enable) begin
      csel_next = periodic_clock_select_wdata;
      intv_next = periodic_interval_wdata;
    end
    // Fresh period on enable; tick sync latency may trim the first one
    if (!periodic_timer_enable || !en_prev_reg) begin
      count_next = '0;
    end else if (elapsed) begin
      count_next = '0;
      wave_next = ~wave_reg;
    end else if (tick_edge) begin
      count_next = count_reg + 16'h0001;
    end
    if (!periodic_timer_enable) wave_next = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lvs_reg <= 1'b0;
      hts_reg <= 1'b0;
      flag_reg <= '0;
      csel_reg <= `PWMI_CLK_SEL_RC;
      intv_reg <= `PWMI_PERIOD_RST;
      count_reg <= '0;
      en_prev_reg <= 1'b0;
      wave_reg <= 1'b0;
    end else begin
      lvs_reg <= lvs_next;
      hts_reg <= hts_next;
      flag_reg <= flag_next;
      csel_reg <= csel_next;
      intv_reg <= intv_next;
      count_reg <= count_next;
      en_prev_reg <= en_prev_next;
      wave_reg <= wave_next;
    end
  end

  assign low_voltage_status = lvs_reg;
  assign high_temp_status = hts_reg;
  assign periodic_clock_select = csel_reg;
  assign periodic_interval = intv_reg;
  assign flags = flag_reg;
  assign irq.low_voltage = flag_reg.low_voltage & low_voltage_irq_enable;
  assign irq.high_temp = flag_reg.high_temp & high_temp_irq_enable;
  assign irq.periodic = flag_reg.periodic & periodic_irq_enable;
  assign periodic_wave_out = wave_reg & periodic_external_enable;

  // Checks
  a_lv_change_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (lvs_reg != $past(lvs_reg)) |-> flag_reg.low_voltage)
    else $error("low voltage change did not set flag");
  a_ht_change_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (hts_reg != $past(hts_reg)) |-> flag_reg.high_temp)
    else $error("high temp change did not set flag");
  a_lv_fpm_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !fpm_s |=> $stable(lvs_reg))
    else $error("low voltage status moved outside full performance");
  a_ht_follow: assert property (@(posedge clk_sys) disable iff (rst)
    fpm_s |=> hts_reg == $past(ht_s))
    else $error("high temp status did not follow comparator");
  a_count_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !periodic_timer_enable |=> count_reg == 16'h0000)
    else $error("timer counted while disabled");
  a_cfg_locked: assert property (@(posedge clk_sys) disable iff (rst)
    periodic_timer_enable |=> $stable(intv_reg) && $stable(csel_reg))
    else $error("config changed while timer enabled");
  a_period_restart: assert property (@(posedge clk_sys) disable iff (rst)
    elapsed |=> flag_reg.periodic && count_reg == 16'h0000)
    else $error("elapse did not set flag and restart");
  a_periodic_irq: assert property (@(posedge clk_sys) disable iff (rst)
    irq.periodic == (flag_reg.periodic && periodic_irq_enable))
    else $error("periodic request mismatch");
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
    flag_clear.periodic && !elapsed |=> !flag_reg.periodic)
    else $error("periodic flag not cleared");
  a_wave_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !periodic_external_enable |-> !periodic_wave_out)
    else $error("wave out without external enable");

  // Request and monitor checks
  a_lv_irq: assert property (@(posedge clk_sys) disable iff (rst)
    irq.low_voltage == (flag_reg.low_voltage && low_voltage_irq_enable))
    else $error("low voltage request mismatch");
  a_ht_irq: assert property (@(posedge clk_sys) disable iff (rst)
    irq.high_temp == (flag_reg.high_temp && high_temp_irq_enable))
    else $error("high temp request mismatch");
  a_lv_follow: assert property (@(posedge clk_sys) disable iff (rst)
    fpm_s |=> lvs_reg == $past(lv_s))
    else $error("low voltage status did not follow comparator");
  a_ht_fpm_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !fpm_s |=> $stable(hts_reg))
    else $error("high temp status moved outside full performance");
  a_lv_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    flag_reg.low_voltage && !flag_clear.low_voltage |=> flag_reg.low_voltage)
    else $error("low voltage flag dropped without clear");
  a_ht_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    flag_reg.high_temp && !flag_clear.high_temp |=> flag_reg.high_temp)
    else $error("high temp flag dropped without clear");

  // Timer checks
  a_count_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    periodic_timer_enable && en_prev_reg && !tick_edge |=> $stable(count_reg))
    else $error("timer moved without a tick");
  a_count_step: assert property (@(posedge clk_sys) disable iff (rst)
    periodic_timer_enable && en_prev_reg && tick_edge && !elapsed
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("timer did not step on tick");
  a_enable_fresh: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(periodic_timer_enable) |=> count_reg == 16'h0000)
    else $error("enable did not start a fresh period");
  a_wave_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    elapsed && en_prev_reg |=> wave_reg != $past(wave_reg))
    else $error("wave did not toggle on elapse");
  a_cfg_load: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_write && !periodic_timer_enable
    |=> intv_reg == $past(periodic_interval_wdata))
    else $error("period write while disabled was lost");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    flag_reg.periodic && !flag_clear.periodic |=> flag_reg.periodic)
    else $error("periodic flag dropped without clear");

endmodule : pwmi_top

// ==== test/pwmi_partner.sv ====
// Far-side model: the two slow timer clocks.
// Assumes clk_sys is the bench clock; ticks run at clk_sys/8.
`timescale 1ns/10ps
module pwmi_partner (
  // Clock and control
  input wire logic clk_sys,
  input wire logic bus_run,
  // Timer clocks
  output logic rc_clock_tick = 1'b0,
  output logic bus_clock_tick = 1'b0
);
  logic [2:0] div_reg = 3'h0;
  always @(posedge clk_sys) begin
    div_reg <= div_reg + 3'h1;
    rc_clock_tick <= div_reg[2];
    // Stopped bus clock stands still
    if (bus_run) bus_clock_tick <= div_reg[2];
  end
endmodule : pwmi_partner

// ==== test/pwmi_top_tb.sv ====
// Bench for monitor flags and periodic timer.
// Assumes pwmi_partner for the timer clocks.
`timescale 1ns/10ps
module pwmi_top_tb;
  import pwmi_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, full_performance_mode = 1'b0, bus_run = 1'b1;
  logic low_voltage_cmp = 1'b0, high_temp_cmp = 1'b0, cfg_write = 1'b0;
  logic low_voltage_irq_enable = 1'b1, high_temp_irq_enable = 1'b1;
  logic periodic_irq_enable = 1'b1, periodic_timer_enable = 1'b0;
  logic periodic_external_enable = 1'b1, periodic_clock_select_wdata = 1'b0;
  logic [15:0] periodic_interval_wdata = 16'h0000, periodic_interval;
  logic rc_clock_tick, bus_clock_tick, low_voltage_status, high_temp_status;
  logic periodic_clock_select, periodic_wave_out, w0;
  pwmi_flag_t flag_clear = '0, flags;
  pwmi_irq_t irq;
  int err_total = 0, tests_run = 0, cyc = 0, n, iv;
  logic [31:0] lfsr = 32'h57df;
  pwmi_top dut_u (.*);
  pwmi_partner partner_u (.*);
  initial forever #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("mismatches %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic w(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : w
  task automatic look;
    @(negedge clk_sys);
  endtask : look
  task automatic clr(input int b);
    w(1);
    flag_clear <= pwmi_flag_t'(3'h1 << b);
    w(1);
    flag_clear <= '0;
    look();
    check(flags[b], 1'b0);
  endtask : clr
  task automatic cfg(input logic [15:0] v, input logic s);
    w(1);
    periodic_interval_wdata <= v;
    periodic_clock_select_wdata <= s;
    cfg_write <= 1'b1;
    w(1);
    cfg_write <= 1'b0;
    look();
  endtask : cfg
  task automatic wflag(output int c);
    c = 0;
    while (flags[0] !== 1'b1 && c < 300) begin
      @(negedge clk_sys);
      c++;
    end
  endtask : wflag
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    look();
    check({periodic_clock_select, periodic_interval, flags}, 20'h0);
    for (int b = 1; b < 3; b++) begin
      w(1);
      {low_voltage_irq_enable, high_temp_irq_enable} <= 2'h3;
      full_performance_mode <= 1'b0;
      {low_voltage_cmp, high_temp_cmp} <= 2'(b);
      w(6);
      look();
      check({low_voltage_status, high_temp_status}, 2'h0);
      w(1);
      full_performance_mode <= 1'b1;
      w(6);
      look();
      check({low_voltage_status, high_temp_status, flags[b], irq[b]}, {2'(b), 2'h3});
      clr(b);
      w(1);
      {low_voltage_irq_enable, high_temp_irq_enable} <= 2'h0;
      {low_voltage_cmp, high_temp_cmp} <= 2'h0;
      w(6);
      look();
      check({low_voltage_status, high_temp_status, flags[b], irq[b]}, 4'h2);
      clr(b);
    end
    lfsr = nxt(lfsr);
    iv = lfsr[2:0];
    cfg(16'(iv), 1'b0);
    check(periodic_interval, 16'(iv));
    w(1);
    periodic_timer_enable <= 1'b1;
    cfg(16'hffff, 1'b1);
    check({periodic_clock_select, periodic_interval}, 17'(iv));
    wflag(n);
    check(irq, 3'h1);
    w0 = periodic_wave_out;
    clr(0);
    wflag(n);
    check(n, (iv + 1) * 8 - 2);
    check(periodic_wave_out, {19'h0, ~w0});
    w(1);
    periodic_external_enable <= 1'b0;
    look();
    check(periodic_wave_out, 1'b0);
    // Disable first, then reconfigure, then re-enable
    w(1);
    periodic_timer_enable <= 1'b0;
    bus_run <= 1'b0;
    cfg(16'(iv), 1'b1);
    clr(0);
    check(periodic_clock_select, 1'b1);
    w(1);
    periodic_timer_enable <= 1'b1;
    wflag(n);
    check(n, 300);
    w(1);
    bus_run <= 1'b1;
    wflag(n);
    check(flags[0], 1'b1);
    summarize();
  end
endmodule : pwmi_top_tb
